/* File: pkg/tdc_pkg.sv */
// Shared constants and types for the touch detect output controller.
`default_nettype none
package tdc_pkg;
    // ********************
    // Clock and timing
    // ********************
    localparam int unsigned CLK_HZ = 25_000_000;
    localparam int unsigned BURST_MS = 75;
    localparam int unsigned CONFIRM_MS = 18;
    localparam int unsigned PULSE_MS = 75;
    localparam int unsigned TONE_MS = 75;
    localparam int unsigned HEALTH_US = 350;
    localparam int unsigned TONE_HZ = 4000;
    localparam int unsigned TMO_SHORT_S = 10;
    localparam int unsigned TMO_LONG_S = 60;
    localparam int unsigned INTEG_LIMIT = 4;
    localparam int unsigned BURST_CYC = BURST_MS * (CLK_HZ / 1000);
    localparam int unsigned CONFIRM_CYC = CONFIRM_MS * (CLK_HZ / 1000);
    localparam int unsigned PULSE_CYC = PULSE_MS * (CLK_HZ / 1000);
    localparam int unsigned TONE_CYC = TONE_MS * (CLK_HZ / 1000);
    localparam int unsigned HEALTH_CYC = HEALTH_US * (CLK_HZ / 1_000_000);
    localparam int unsigned TONE_HALF_CYC = CLK_HZ / (2 * TONE_HZ);
    localparam int unsigned TMO_SHORT_CYC = TMO_SHORT_S * CLK_HZ;
    localparam int unsigned TMO_LONG_CYC = TMO_LONG_S * CLK_HZ;
    // ********************
    // Register map
    // ********************
    localparam logic [3:0] CTRL_OFS = 4'h0;
    localparam logic [3:0] STAT_OFS = 4'h4;
    localparam int unsigned CTRL_EN_BIT = 0;
    localparam logic CTRL_EN_RST = 1'b1;
    localparam int unsigned STAT_ACT_BIT = 0;
    localparam int unsigned STAT_CONF_BIT = 1;
    localparam int unsigned STAT_CNT_LSB = 2;
    localparam int unsigned STAT_MODE_LSB = 5;
    localparam int unsigned STAT_LONG_BIT = 7;
    // ********************
    // Types
    // ********************
    typedef enum logic [1:0] {SEQ_WAIT, SEQ_HEALTH, SEQ_ACQ} tdc_seq_t;
    typedef enum logic [1:0] {MODE_STEADY, MODE_TOGGLE, MODE_PULSE} tdc_mode_t;
endpackage
`default_nettype wire

/* File: logic/tdc_top.sv */
// Touch detect output controller: integrator, burst timing, output modes, tone.
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - Integrator counts consecutive burst detections; output activates at four.
// - A burst without detection before the final count clears the integrator.
// - Bursts every 75ms; three confirmation bursts follow at 18ms.
// - No recalibration input; recalibration comes from power-up reset.
// - Option straps are captured once after power-up only.
// - Straps pick steady 10s, steady 60s, toggle 10s or pulse 10s.
// - Detection lasting past the timeout forces full recalibration.
// - Steady mode: active while detected or until timeout, then inactive.
// - Steady mode timeout is 10 or 60 seconds.
// - Toggle mode inverts the output on every new confirmed detection.
// - Toggle mode timeout is 10s and keeps the output state.
// - Pulse mode emits one 75ms active pulse per new detection.
// - Pulse mode timeout is fixed at 10 seconds.
// - Output polarity is a build-time choice; active level means detection.
// - Output floats 350us before every burst as a health pulse.
// - A 75ms piezo tone starts right after each new detection.
// - Tone drives both sense pins in anti-phase at 4kHz.
module tdc_top #(
    parameter bit ACTIVE_HIGH = 1'b0,
    parameter int unsigned BURST_CYC = tdc_pkg::BURST_CYC,
    parameter int unsigned CONFIRM_CYC = tdc_pkg::CONFIRM_CYC,
    parameter int unsigned PULSE_CYC = tdc_pkg::PULSE_CYC,
    parameter int unsigned TONE_CYC = tdc_pkg::TONE_CYC,
    parameter int unsigned HEALTH_CYC = tdc_pkg::HEALTH_CYC,
    parameter int unsigned TONE_HALF_CYC = tdc_pkg::TONE_HALF_CYC,
    parameter int unsigned TMO_SHORT_CYC = tdc_pkg::TMO_SHORT_CYC,
    parameter int unsigned TMO_LONG_CYC = tdc_pkg::TMO_LONG_CYC
) (
    input wire logic sys_clk, // System clock, 25 MHz.
    input wire logic srst, // Synchronous reset, stands for power-up.
    input wire logic option_strap_a, // First option strap.
    input wire logic option_strap_b, // Second option strap.
    input wire logic acq_done, // One-cycle end of burst from front end.
    input wire logic acq_detect, // Detect flag, valid with acq_done.
    output var logic burst_start, // One-cycle request to run a burst.
    output var logic recal, // One-cycle full recalibration request.
    output var logic out_o, // Output pin level.
    output var logic out_oe, // Output pin drive enable.
    output var logic sense_pin_a_o, // Sense pin A tone level.
    output var logic sense_pin_a_oe, // Sense pin A tone drive enable.
    output var logic sense_pin_b_o, // Sense pin B tone level.
    output var logic sense_pin_b_oe, // Sense pin B tone drive enable.
    input wire logic [3:0] avs_address, // Byte address.
    input wire logic avs_read, // Read request.
    input wire logic avs_write, // Write request.
    input wire logic [31:0] avs_writedata, // Write data.
    input wire logic [3:0] avs_byteenable, // Byte lanes.
    output var logic [31:0] avs_readdata, // Read data.
    output var logic avs_waitrequest // Stall until answer.
);
    localparam logic [2:0] LIMIT = 3'(tdc_pkg::INTEG_LIMIT);

    function automatic logic [31:0] dec(input logic [31:0] v);
        dec = (v == 32'h0) ? 32'h0 : v - 32'h1;
    endfunction

    // ********************
    // Bus slave
    // ********************
    logic wait_r, wait_nxt, en_r, en_nxt;
    logic [31:0] rdata_r, rdata_nxt, stat;
    tdc_pkg::tdc_seq_t st_r, st_nxt;
    tdc_pkg::tdc_mode_t mode_r, mode_nxt;
    logic [2:0] icnt_r, icnt_nxt;
    logic act_r, act_nxt, long_r, long_nxt, straps_r, straps_nxt;

    always_comb begin
        stat = 32'h0;
        stat[tdc_pkg::STAT_ACT_BIT] = act_r;
        stat[tdc_pkg::STAT_CONF_BIT] = (icnt_r == LIMIT);
        stat[tdc_pkg::STAT_CNT_LSB +: 3] = icnt_r;
        stat[tdc_pkg::STAT_MODE_LSB +: 2] = mode_r;
        stat[tdc_pkg::STAT_LONG_BIT] = long_r;
        wait_nxt = ~((avs_read | avs_write) & wait_r);
        en_nxt = en_r;
        rdata_nxt = rdata_r;
        if ((avs_read | avs_write) & wait_r) begin
            rdata_nxt = 32'h0;
            if (avs_read && avs_address == tdc_pkg::CTRL_OFS) begin
                rdata_nxt[tdc_pkg::CTRL_EN_BIT] = en_r;
            end else if (avs_read && avs_address == tdc_pkg::STAT_OFS) begin
                rdata_nxt = stat;
            end
        end
        if (avs_write && !wait_r && avs_address == tdc_pkg::CTRL_OFS && avs_byteenable[0]) begin
            en_nxt = avs_writedata[tdc_pkg::CTRL_EN_BIT];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            wait_r <= 1'b1;
            en_r <= tdc_pkg::CTRL_EN_RST;
            rdata_r <= 32'h0;
        end else begin
            wait_r <= wait_nxt;
            en_r <= en_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign avs_waitrequest = wait_r;
    assign avs_readdata = rdata_r;

    // ********************
    // Sensing core
    // ********************
    logic [31:0] wcnt_r, wcnt_nxt, tcnt_r, tcnt_nxt, pcnt_r, pcnt_nxt;
    logic [31:0] tone_r, tone_nxt, half_r, half_nxt, tmo_lim;
    logic phase_r, phase_nxt, tone_on_r, tone_on_nxt;
    logic burst_nxt, recal_nxt, out_nxt, oe_nxt, new_det, tmo_hit;

    always_comb begin
        st_nxt = st_r;
        mode_nxt = mode_r;
        long_nxt = long_r;
        straps_nxt = straps_r;
        wcnt_nxt = wcnt_r;
        icnt_nxt = icnt_r;
        tcnt_nxt = tcnt_r;
        pcnt_nxt = pcnt_r;
        tone_nxt = tone_r;
        half_nxt = half_r;
        phase_nxt = phase_r;
        act_nxt = act_r;
        burst_nxt = 1'b0;
        recal_nxt = 1'b0;
        tmo_hit = 1'b0;
        tmo_lim = long_r ? TMO_LONG_CYC : TMO_SHORT_CYC;
        if (!straps_r) begin
            straps_nxt = 1'b1;
            recal_nxt = 1'b1;
            long_nxt = option_strap_a & ~option_strap_b;
            case ({option_strap_a, option_strap_b})
                2'b00: mode_nxt = tdc_pkg::MODE_TOGGLE;
                2'b01: mode_nxt = tdc_pkg::MODE_PULSE;
                default: mode_nxt = tdc_pkg::MODE_STEADY;
            endcase
        end
        if (st_r == tdc_pkg::SEQ_ACQ && acq_done) begin
            if (acq_detect) begin
                if (icnt_r < LIMIT) begin
                    icnt_nxt = icnt_r + 3'h1;
                end
            end else begin
                icnt_nxt = 3'h0;
            end
        end
        if (icnt_r == LIMIT) begin
            if (tcnt_r >= tmo_lim - 32'h1) begin
                tmo_hit = 1'b1;
                recal_nxt = 1'b1;
                icnt_nxt = 3'h0;
                tcnt_nxt = 32'h0;
            end else begin
                tcnt_nxt = tcnt_r + 32'h1;
            end
        end else begin
            tcnt_nxt = 32'h0;
        end
        new_det = (icnt_nxt == LIMIT) && (icnt_r != LIMIT);
        case (st_r)
            tdc_pkg::SEQ_WAIT: begin
                if (wcnt_r != 32'h0) begin
                    wcnt_nxt = dec(wcnt_r);
                end else if (en_r) begin
                    st_nxt = tdc_pkg::SEQ_HEALTH;
                    wcnt_nxt = HEALTH_CYC - 32'h1;
                end
            end
            tdc_pkg::SEQ_HEALTH: begin
                if (wcnt_r != 32'h0) begin
                    wcnt_nxt = dec(wcnt_r);
                end else begin
                    st_nxt = tdc_pkg::SEQ_ACQ;
                    burst_nxt = 1'b1;
                end
            end
            tdc_pkg::SEQ_ACQ: begin
                if (acq_done) begin
                    st_nxt = tdc_pkg::SEQ_WAIT;
                    if (icnt_nxt != 3'h0 && icnt_nxt < LIMIT) begin
                        wcnt_nxt = CONFIRM_CYC - HEALTH_CYC;
                    end else begin
                        wcnt_nxt = BURST_CYC - HEALTH_CYC;
                    end
                end
            end
            default: st_nxt = tdc_pkg::SEQ_WAIT;
        endcase
        case (mode_r)
            tdc_pkg::MODE_STEADY: act_nxt = (icnt_nxt == LIMIT);
            tdc_pkg::MODE_TOGGLE: begin
                if (new_det) begin
                    act_nxt = ~act_r;
                end
            end
            tdc_pkg::MODE_PULSE: begin
                if (new_det) begin
                    pcnt_nxt = PULSE_CYC - 32'h1;
                    act_nxt = 1'b1;
                end else if (pcnt_r != 32'h0) begin
                    pcnt_nxt = dec(pcnt_r);
                end else begin
                    act_nxt = 1'b0;
                end
            end
            default: act_nxt = 1'b0;
        endcase
        if (new_det) begin
            tone_nxt = TONE_CYC - 32'h1;
            half_nxt = TONE_HALF_CYC - 32'h1;
            phase_nxt = 1'b0;
        end else if (tone_r != 32'h0) begin
            tone_nxt = dec(tone_r);
            if (half_r == 32'h0) begin
                half_nxt = TONE_HALF_CYC - 32'h1;
                phase_nxt = ~phase_r;
            end else begin
                half_nxt = dec(half_r);
            end
        end
        tone_on_nxt = new_det | (tone_r > 32'h1);
        out_nxt = act_nxt ^ ~ACTIVE_HIGH;
        oe_nxt = (st_nxt != tdc_pkg::SEQ_HEALTH);
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            st_r <= tdc_pkg::SEQ_WAIT;
            mode_r <= tdc_pkg::MODE_STEADY;
            long_r <= 1'b0;
            straps_r <= 1'b0;
            wcnt_r <= 32'h0;
            icnt_r <= 3'h0;
            tcnt_r <= 32'h0;
            pcnt_r <= 32'h0;
            tone_r <= 32'h0;
            half_r <= 32'h0;
            phase_r <= 1'b0;
            tone_on_r <= 1'b0;
            act_r <= 1'b0;
            burst_start <= 1'b0;
            recal <= 1'b0;
            out_o <= ~ACTIVE_HIGH;
            out_oe <= 1'b1;
            sense_pin_a_o <= 1'b0;
            sense_pin_b_o <= 1'b1;
            sense_pin_a_oe <= 1'b0;
            sense_pin_b_oe <= 1'b0;
        end else begin
            st_r <= st_nxt;
            mode_r <= mode_nxt;
            long_r <= long_nxt;
            straps_r <= straps_nxt;
            wcnt_r <= wcnt_nxt;
            icnt_r <= icnt_nxt;
            tcnt_r <= tcnt_nxt;
            pcnt_r <= pcnt_nxt;
            tone_r <= tone_nxt;
            half_r <= half_nxt;
            phase_r <= phase_nxt;
            tone_on_r <= tone_on_nxt;
            act_r <= act_nxt;
            burst_start <= burst_nxt;
            recal <= recal_nxt;
            out_o <= out_nxt;
            out_oe <= oe_nxt;
            sense_pin_a_o <= phase_nxt;
            sense_pin_b_o <= ~phase_nxt;
            sense_pin_a_oe <= tone_on_nxt;
            sense_pin_b_oe <= tone_on_nxt;
        end
    end

    // ********************
    // Checks
    // ********************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    property p_int_four;
        $rose(icnt_r == LIMIT) |-> $past(icnt_r) == 3'h3;
    endproperty
    a_int_four: assert property (p_int_four) else $error("confirm without count three");

    property p_int_clear;
        (st_r == tdc_pkg::SEQ_ACQ && acq_done && !acq_detect) |=> icnt_r == 3'h0;
    endproperty
    a_int_clear: assert property (p_int_clear) else $error("integrator not cleared");

    property p_fast_space;
        (st_r == tdc_pkg::SEQ_ACQ && acq_done && acq_detect && icnt_r < 3'h3 && tcnt_r == 32'h0)
            |=> wcnt_r == CONFIRM_CYC - HEALTH_CYC;
    endproperty
    a_fast_space: assert property (p_fast_space) else $error("confirm spacing wrong");

    property p_straps_hold;
        straps_r |=> $stable(mode_r) && $stable(long_r);
    endproperty
    a_straps_hold: assert property (p_straps_hold) else $error("straps changed");

    property p_timeout;
        (icnt_r == LIMIT && tcnt_r == tmo_lim - 32'h1) |=> recal && icnt_r == 3'h0;
    endproperty
    a_timeout: assert property (p_timeout) else $error("timeout missed");

    property p_steady;
        (straps_r && mode_r == tdc_pkg::MODE_STEADY) ##1 1'b1 |-> act_r == (icnt_r == LIMIT);
    endproperty
    a_steady: assert property (p_steady) else $error("steady output wrong");

    property p_toggle_keep;
        (mode_r == tdc_pkg::MODE_TOGGLE && tmo_hit) |=> $stable(act_r);
    endproperty
    a_toggle_keep: assert property (p_toggle_keep) else $error("toggle lost state");

    property p_pulse;
        (mode_r == tdc_pkg::MODE_PULSE && new_det) |=> act_r [*8];
    endproperty
    a_pulse: assert property (p_pulse) else $error("pulse too short");

    property p_health;
        burst_start |-> $past(!out_oe);
    endproperty
    a_health: assert property (p_health) else $error("no health float");

    property p_tone;
        sense_pin_a_oe |-> (sense_pin_a_o != sense_pin_b_o) && sense_pin_b_oe;
    endproperty
    a_tone: assert property (p_tone) else $error("tone not complementary");
endmodule
`default_nettype wire

/* File: dv/tdc_fe_model.sv */
// Acquisition front end and output load model facing the controller.
`timescale 1ns/100ps
`default_nettype none
module tdc_fe_model (
    input wire logic sys_clk, // Clock.
    input wire logic burst_start, // Burst request.
    input wire logic touch, // Object present.
    input wire logic [1:0] delay, // Extra burst cycles.
    input wire logic out_o, // Output level.
    input wire logic out_oe, // Output enable.
    output var logic acq_done, // End of burst.
    output var logic acq_detect, // Detect flag.
    output var logic out_pin // Resolved output pin.
);
    logic bias_r = 1'b0;
    // The bias resistor is switched to the inverse of the driven level.
    always @(posedge sys_clk) if (out_oe) bias_r <= ~out_o;
    assign out_pin = out_oe ? out_o : bias_r;
    // One flag per burst, answered promptly or late; junk on the flag otherwise.
    initial begin
        acq_done = 1'b0;
        acq_detect = 1'b0;
        forever begin
            @(posedge sys_clk);
            if (burst_start === 1'b1) begin
                repeat (delay) @(posedge sys_clk);
                acq_done <= 1'b1;
                acq_detect <= touch;
                @(posedge sys_clk);
                acq_done <= 1'b0;
                acq_detect <= ~touch;
            end
        end
    end
endmodule
`default_nettype wire

/* File: dv/tb_top.sv */
// Self-checking bench for the touch detect output controller.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, s) begin num_checks++; if ((s) !== (e)) begin n_fail++; \
    $display("BAD %s exp %0h got %0h", nm, e, s); end end
module tb_top;
    localparam bit ACT = 1'b0;
    localparam int BC = 200;
    localparam int CC = 60;
    localparam int HC = 10;
    logic sys_clk = 1'b0, srst = 1'b1, option_strap_a = 1'b0, option_strap_b = 1'b0;
    logic touch = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
    logic [1:0] dly = 2'h0;
    logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hF;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
    logic acq_done, acq_detect, burst_start, recal, out_o, out_oe, out_pin, avs_waitrequest;
    logic sense_pin_a_o, sense_pin_a_oe, sense_pin_b_o, sense_pin_b_oe;
    int n_fail, num_checks, cyc, mode, tmo_lim, m_cnt, m_tmo, rc_exp, rc_seen, gap, oe_lo, w, c, nb;
    bit m_conf, m_out, m_new, have_acq, mon_on, ta, pend;
    tdc_top #(.ACTIVE_HIGH(ACT), .BURST_CYC(BC), .CONFIRM_CYC(CC), .PULSE_CYC(20),
        .TONE_CYC(40), .HEALTH_CYC(HC), .TONE_HALF_CYC(4), .TMO_SHORT_CYC(300),
        .TMO_LONG_CYC(900)) tdc_top_i (.sys_clk, .srst, .option_strap_a, .option_strap_b,
        .acq_done, .acq_detect, .burst_start, .recal, .out_o, .out_oe, .sense_pin_a_o,
        .sense_pin_a_oe, .sense_pin_b_o, .sense_pin_b_oe, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest);
    tdc_fe_model tdc_fe_model_i (.sys_clk, .burst_start, .touch, .delay(dly), .out_o,
        .out_oe, .acq_done, .acq_detect, .out_pin);
    always #20 sys_clk = ~sys_clk;
    // ********************
    // Bus and closing tasks
    // ********************
    task automatic bus(input bit wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= ~wr;
        avs_writedata <= d;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 40000) begin
            n_fail++;
            tally_and_finish();
        end
    end
    // ********************
    // Reference model
    // ********************
    always @(posedge sys_clk) begin
        if (burst_start === 1'b1) nb++;
        if (!srst && mon_on) begin
            gap++;
            if (out_pin !== out_o) oe_lo++;
            if (recal === 1'b1) rc_seen++;
            if (burst_start === 1'b1) begin
                pend = 1;
                `CHK("health", HC, oe_lo)
                if (have_acq) `CHK("spacing", 1'b1, gap >= w && gap <= w + 3)
                oe_lo = 0;
            end
            if (m_conf) begin
                m_tmo++;
                if (m_tmo == tmo_lim) begin
                    m_conf = 0;
                    m_cnt = 0;
                    rc_exp++;
                    if (mode == 0) m_out = 0;
                end
            end
            if (acq_done === 1'b1 && pend) begin
                pend = 0;
                gap = 0;
                have_acq = 1;
                c = 1;
                m_new = 0;
                if (acq_detect) begin
                    if (m_cnt < 4) m_cnt++;
                    if (m_cnt == 4 && !m_conf) begin
                        m_conf = 1;
                        m_new = 1;
                        m_tmo = 0;
                        m_out = mode == 1 ? !m_out : 1'b1;
                    end
                end else begin
                    m_cnt = 0;
                    m_conf = 0;
                    if (mode != 1) m_out = 0;
                end
                w = (m_cnt > 0 && m_cnt < 4) ? CC : BC;
            end else if (c > 0) c++;
            if (c == 4) begin
                `CHK("out", m_out ? ACT : ~ACT, out_o)
                `CHK("tone", m_new, sense_pin_a_oe && sense_pin_a_o !== sense_pin_b_o)
                `CHK("tone_b", m_new, sense_pin_b_oe)
                ta = sense_pin_a_o;
                if (mode == 2) m_out = 0;
            end
            if (c == 8) begin
                if (m_new) `CHK("tone_hz", ~ta, sense_pin_a_o)
                c = 0;
            end
        end
    end
    // ********************
    // Stimulus
    // ********************
    initial begin
        void'($urandom(61704));
        for (int k = 0; k < 4; k++) begin
            option_strap_a <= k < 2;
            option_strap_b <= k == 0 || k == 3;
            mode = k < 2 ? 0 : k - 1;
            tmo_lim = k == 1 ? 900 : 300;
            touch <= 1'b0;
            srst <= 1'b1;
            mon_on = 0;
            repeat (3) @(posedge sys_clk);
            srst <= 1'b0;
            m_cnt = 0;
            m_conf = 0;
            m_out = 0;
            have_acq = 0;
            pend = 0;
            c = 0;
            oe_lo = 0;
            rc_seen = 0;
            rc_exp = 1;
            mon_on = 1;
            @(posedge sys_clk);
            option_strap_a <= k >= 2;
            option_strap_b <= !(k == 0 || k == 3);
            bus(0, 4'h4, 32'h0);
            `CHK("status", {k == 1, mode[1:0], 5'h00}, q[7:0])
            `CHK("out_idle", ~ACT, out_o)
            repeat (30) begin
                repeat (60) @(posedge sys_clk);
                touch <= ($urandom % 3) != 0;
                dly <= 2'($urandom);
            end
            touch <= 1'b1;
            repeat (k == 1 ? 2600 : 1000) @(posedge sys_clk);
            touch <= 1'b0;
            repeat (600) @(posedge sys_clk);
            touch <= 1'b1;
            repeat (700) @(posedge sys_clk);
            touch <= 1'b0;
            repeat (500) @(posedge sys_clk);
            `CHK("recal", rc_exp, rc_seen)
            bus(0, 4'h4, 32'h0);
            `CHK("strap_hold", {k == 1, mode[1:0]}, q[7:5])
        end
        mon_on = 0;
        bus(0, 4'h0, 32'h0);
        `CHK("ctrl_rst", 1'b1, q[0])
        avs_byteenable <= 4'hE;
        bus(1, 4'h0, 32'h0);
        avs_byteenable <= 4'hF;
        bus(0, 4'h0, 32'h0);
        `CHK("be_mask", 1'b1, q[0])
        bus(1, 4'h0, 32'h0);
        repeat (20) @(posedge sys_clk);
        nb = 0;
        repeat (400) @(posedge sys_clk);
        `CHK("halt", 0, nb)
        bus(0, 4'h0, 32'h0);
        `CHK("ctrl", 1'b0, q[0])
        bus(1, 4'h0, 32'h1);
        bus(0, 4'h8, 32'h0);
        `CHK("unmapped", 32'h0, q)
        repeat (300) @(posedge sys_clk);
        `CHK("resume", 1'b1, nb > 0)
        tally_and_finish();
    end
endmodule
`default_nettype wire
